//--- rsa_alu_map.vh
/*
 register offsets, field positions, operation codes and reset values for the
 rotate / subtract / skip execution block; included by rsa_alu.v and by the self-checking bench
*/
`ifndef RSA_ALU_MAP_VH
`define RSA_ALU_MAP_VH

// byte offsets of the word registers on the bus
`define RSA_OFS_CTRL 8'h00
`define RSA_OFS_ACC 8'h04
`define RSA_OFS_MEM 8'h08
`define RSA_OFS_IMM 8'h0C
`define RSA_OFS_FLAGS 8'h10
`define RSA_OFS_STATUS 8'h14

// control word fields: operation code and bit select
`define RSA_CTRL_OP_LSB 0
`define RSA_CTRL_OP_MSB 4
`define RSA_CTRL_BIT_LSB 8
`define RSA_CTRL_BIT_MSB 10

// flag register bit positions
`define RSA_FLAG_C 0
`define RSA_FLAG_AUX 1
`define RSA_FLAG_Z 2
`define RSA_FLAG_OVF 3

// status register bit positions
`define RSA_STAT_BUSY 0
`define RSA_STAT_SKIP 1
`define RSA_STAT_MEMWR 2

// reset values
`define RSA_RST_BYTE 8'h00
`define RSA_RST_OP 5'h00

// operation codes
`define RSA_OP_ROTATE_LEFT_CARRY_MEM 5'h00
`define RSA_OP_ROTATE_LEFT_CARRY_TO_ACC 5'h01
`define RSA_OP_ROTATE_RIGHT_MEM 5'h02
`define RSA_OP_ROTATE_RIGHT_TO_ACC 5'h03
`define RSA_OP_ROTATE_RIGHT_CARRY_MEM 5'h04
`define RSA_OP_ROTATE_RIGHT_CARRY_TO_ACC 5'h05
`define RSA_OP_SUBTRACT_BORROW_TO_ACC 5'h06
`define RSA_OP_SUBTRACT_BORROW_TO_MEM 5'h07
`define RSA_OP_SUBTRACT_TO_ACC 5'h08
`define RSA_OP_SUBTRACT_TO_MEM 5'h09
`define RSA_OP_SUBTRACT_IMM_TO_ACC 5'h0A
`define RSA_OP_DECREMENT_SKIP_ZERO 5'h0B
`define RSA_OP_DECREMENT_SKIP_ZERO_TO_ACC 5'h0C
`define RSA_OP_INCREMENT_SKIP_ZERO 5'h0D
`define RSA_OP_INCREMENT_SKIP_ZERO_TO_ACC 5'h0E
`define RSA_OP_SKIP_BIT_NONZERO 5'h0F
`define RSA_OP_SET_BYTE 5'h10
`define RSA_OP_SET_BIT 5'h11
`define RSA_OP_NIBBLE_EXCHANGE_MEM 5'h12
`define RSA_OP_NIBBLE_EXCHANGE_TO_ACC 5'h13

// value written by the set-byte operation
`define RSA_ALL_ONES 8'hFF

`endif

//--- rsa_alu.v
/*
 execution datapath for rotate, subtract, skip, set and nibble-swap operations
 of an 8-bit controller, with accumulator, addressed memory byte, immediate
 operand and flags held as AHB-Lite slave registers.
 assumes a single AHB-Lite master on hclk, word transfers only, and that
 the fetch stage honours skip_o by discarding its already fetched word.
*/
// Behaviour
// RL1: memory rotate left through carry, carry only
// RL2: accumulator rotate left through carry, memory kept
// RL3: memory rotate right, no flag changes
// RL4: accumulator rotate right, memory and flags kept
// RL5: memory rotate right through carry, carry only
// RL6: accumulator rotate right through carry, memory kept
// RL7: subtract with borrow, four arithmetic flags
// RL8: subtract memory byte, four arithmetic flags
// RL9: subtract immediate into accumulator, four flags
// RL10: memory decrement, skip on zero, no flags
// RL11: accumulator gets decrement, skip on zero
// RL12: memory increment, skip on zero, no flags
// RL13: accumulator gets increment, skip on zero
// RL14: skip adds one dummy cycle, else none
// RL15: skip when selected memory bit is one
// RL16: set byte writes all ones, no flags
// RL17: set bit forces selected bit only
// RL18: nibble swap written back, no flags
// RL19: nibble swap into accumulator, memory kept
// RL20: carry is adder carry-out, zero on result
`timescale 1ns/100ps
`default_nettype none
`include "rsa_alu_map.vh"

module rsa_alu (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // towards fetch stage
   output reg skip_o,
   output reg done_o
);

   // execution states
   localparam ST_IDLE = 2'd0;
   localparam ST_EXEC = 2'd1;
   localparam ST_DUMMY = 2'd2;

   // architectural state
   reg [7:0] acc_r; // accumulator
   reg [7:0] mem_r; // addressed data memory byte
   reg [7:0] imm_r; // immediate operand
   reg c_r; // carry flag
   reg aux_r; // aux carry flag
   reg z_r; // zero flag
   reg ovf_r; // overflow flag
   reg [4:0] op_r; // latched operation
   reg [2:0] bit_r; // latched bit select
   reg skip_last_r; // last operation skipped
   reg memwr_last_r; // last operation wrote memory
   reg [1:0] state_r; // execution state
   reg [1:0] state_nxt;

   // bus pipeline
   reg dp_valid_r; // data phase pending
   reg dp_write_r; // pending phase is a write
   reg [7:0] dp_addr_r; // pending phase address

   // next values, also feed the read path so write-then-read is coherent
   reg [7:0] acc_nxt;
   reg [7:0] mem_nxt;
   reg [7:0] imm_nxt;
   reg c_nxt;
   reg aux_nxt;
   reg z_nxt;
   reg ovf_nxt;
   reg skip_last_nxt;
   reg memwr_last_nxt;

   // datapath results
   reg [7:0] res; // operation result
   reg to_mem; // result goes to memory byte
   reg to_acc; // result goes to accumulator
   reg c_new; // carry produced
   reg arith; // subtract updates all four flags
   reg skip; // skip condition
   wire [7:0] sub_b; // subtrahend
   wire sub_cin; // carry into adder
   wire [8:0] sub_sum; // nine bit adder output
   wire [4:0] sub_low; // low nibble adder output
   wire sub_ovf; // signed overflow
   wire [7:0] dec_val; // memory minus one
   wire [7:0] inc_val; // memory plus one

   // bus decode
   wire accept; // address phase taken this edge
   wire wr_done; // write data phase completes
   wire start; // control word written
   wire [7:0] rd_addr; // address the read path looks at
   wire [31:0] rd_word; // read mux output

   // read mux: data registers are byte wide, control uses bits 10:0, upper bits read zero
   function [31:0] rsa_read;
      input [7:0] a;
      input [7:0] acc;
      input [7:0] mem;
      input [7:0] imm;
      input [3:0] flags;
      input [2:0] stat;
      input [4:0] op;
      input [2:0] bsel;
      begin
         if (a == `RSA_OFS_CTRL) begin
            rsa_read = {21'h000000, bsel, 3'h0, op};
         end else if (a == `RSA_OFS_ACC) begin
            rsa_read = {24'h000000, acc};
         end else if (a == `RSA_OFS_MEM) begin
            rsa_read = {24'h000000, mem};
         end else if (a == `RSA_OFS_IMM) begin
            rsa_read = {24'h000000, imm};
         end else if (a == `RSA_OFS_FLAGS) begin
            rsa_read = {28'h0000000, flags};
         end else if (a == `RSA_OFS_STATUS) begin
            rsa_read = {29'h00000000, stat};
         end else begin
            // unmapped words read zero with an okay response
            rsa_read = 32'h00000000;
         end
      end
   endfunction

   // subtract is add of the inverted operand plus carry in
   assign sub_b = (op_r == `RSA_OP_SUBTRACT_IMM_TO_ACC) ? imm_r : mem_r; // RL9
   assign sub_cin = (op_r == `RSA_OP_SUBTRACT_BORROW_TO_ACC ||
                     op_r == `RSA_OP_SUBTRACT_BORROW_TO_MEM) ? c_r : 1'b1; // RL7
   assign sub_sum = {1'b0, acc_r} + {1'b0, ~sub_b} + {8'h00, sub_cin}; // RL8
   assign sub_low = {1'b0, acc_r[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
   // overflow when both addends share a sign that the result lacks
   assign sub_ovf = (acc_r[7] == ~sub_b[7]) && (sub_sum[7] != acc_r[7]);
   assign dec_val = mem_r - 8'h01;
   assign inc_val = mem_r + 8'h01;

   // operation decode and result selection
   always @* begin
      res = mem_r;
      to_mem = 1'b0;
      to_acc = 1'b0;
      c_new = c_r;
      arith = 1'b0;
      skip = 1'b0;
      case (op_r)
         `RSA_OP_ROTATE_LEFT_CARRY_MEM: begin
            res = {mem_r[6:0], c_r}; // RL1
            c_new = mem_r[7]; // RL1
            to_mem = 1'b1;
         end
         `RSA_OP_ROTATE_LEFT_CARRY_TO_ACC: begin
            res = {mem_r[6:0], c_r}; // RL2
            c_new = mem_r[7]; // RL2
            to_acc = 1'b1;
         end
         `RSA_OP_ROTATE_RIGHT_MEM: begin
            res = {mem_r[0], mem_r[7:1]}; // RL3
            to_mem = 1'b1;
         end
         `RSA_OP_ROTATE_RIGHT_TO_ACC: begin
            res = {mem_r[0], mem_r[7:1]}; // RL4
            to_acc = 1'b1;
         end
         `RSA_OP_ROTATE_RIGHT_CARRY_MEM: begin
            res = {c_r, mem_r[7:1]}; // RL5
            c_new = mem_r[0]; // RL5
            to_mem = 1'b1;
         end
         `RSA_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
            res = {c_r, mem_r[7:1]}; // RL6
            c_new = mem_r[0]; // RL6
            to_acc = 1'b1;
         end
         `RSA_OP_SUBTRACT_BORROW_TO_ACC,
         `RSA_OP_SUBTRACT_TO_ACC,
         `RSA_OP_SUBTRACT_IMM_TO_ACC: begin
            res = sub_sum[7:0]; // RL7 RL8 RL9
            c_new = sub_sum[8]; // RL20
            arith = 1'b1;
            to_acc = 1'b1;
         end
         `RSA_OP_SUBTRACT_BORROW_TO_MEM,
         `RSA_OP_SUBTRACT_TO_MEM: begin
            res = sub_sum[7:0]; // RL7 RL8
            c_new = sub_sum[8]; // RL20
            arith = 1'b1;
            to_mem = 1'b1;
         end
         `RSA_OP_DECREMENT_SKIP_ZERO: begin
            res = dec_val; // RL10
            skip = (dec_val == 8'h00); // RL10
            to_mem = 1'b1;
         end
         `RSA_OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
            res = dec_val; // RL11
            skip = (dec_val == 8'h00); // RL11
            to_acc = 1'b1;
         end
         `RSA_OP_INCREMENT_SKIP_ZERO: begin
            res = inc_val; // RL12
            skip = (inc_val == 8'h00); // RL12
            to_mem = 1'b1;
         end
         `RSA_OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
            res = inc_val; // RL13
            skip = (inc_val == 8'h00); // RL13
            to_acc = 1'b1;
         end
         `RSA_OP_SKIP_BIT_NONZERO: begin
            // pure test: nothing is written
            skip = mem_r[bit_r]; // RL15
         end
         `RSA_OP_SET_BYTE: begin
            res = `RSA_ALL_ONES; // RL16
            to_mem = 1'b1;
         end
         `RSA_OP_SET_BIT: begin
            res = mem_r | (8'h01 << bit_r); // RL17
            to_mem = 1'b1;
         end
         `RSA_OP_NIBBLE_EXCHANGE_MEM: begin
            res = {mem_r[3:0], mem_r[7:4]}; // RL18
            to_mem = 1'b1;
         end
         `RSA_OP_NIBBLE_EXCHANGE_TO_ACC: begin
            res = {mem_r[3:0], mem_r[7:4]}; // RL19
            to_acc = 1'b1;
         end
         default: begin
            // unused codes behave as a no-operation
            res = mem_r;
         end
      endcase
   end

   // bus handshakes
   assign accept = hsel && htrans[1] && hready;
   assign wr_done = dp_valid_r && hreadyout && dp_write_r;
   assign start = wr_done && (dp_addr_r == `RSA_OFS_CTRL);

   // execution sequencing: exec cycle, then a dummy cycle if skipping
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_nxt = skip ? ST_DUMMY : ST_IDLE; // RL14
         end
         ST_DUMMY: begin
            state_nxt = ST_IDLE; // RL14
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // next register values; bus writes only land while idle, so they never
   // collide with an execution update
   always @* begin
      acc_nxt = acc_r;
      mem_nxt = mem_r;
      imm_nxt = imm_r;
      c_nxt = c_r;
      aux_nxt = aux_r;
      z_nxt = z_r;
      ovf_nxt = ovf_r;
      skip_last_nxt = skip_last_r;
      memwr_last_nxt = memwr_last_r;
      if (state_r == ST_EXEC) begin
         // memory byte and accumulator are updated exclusively
         if (to_mem) begin
            mem_nxt = res;
         end
         if (to_acc) begin
            acc_nxt = res;
         end
         // rotates through carry touch carry only; all other non-arithmetic ops keep c_new = c_r
         c_nxt = c_new;
         if (arith) begin
            aux_nxt = sub_low[4]; // RL7
            ovf_nxt = sub_ovf; // RL8
            z_nxt = (sub_sum[7:0] == 8'h00); // RL20
         end
         skip_last_nxt = skip;
         memwr_last_nxt = to_mem;
      end else if (wr_done) begin
         if (dp_addr_r == `RSA_OFS_ACC) begin
            acc_nxt = hwdata[7:0];
         end else if (dp_addr_r == `RSA_OFS_MEM) begin
            mem_nxt = hwdata[7:0];
         end else if (dp_addr_r == `RSA_OFS_IMM) begin
            imm_nxt = hwdata[7:0];
         end else if (dp_addr_r == `RSA_OFS_FLAGS) begin
            c_nxt = hwdata[`RSA_FLAG_C];
            aux_nxt = hwdata[`RSA_FLAG_AUX];
            z_nxt = hwdata[`RSA_FLAG_Z];
            ovf_nxt = hwdata[`RSA_FLAG_OVF];
         end
      end
   end

   // read path looks at the next address phase, or the stalled one
   assign rd_addr = accept ? haddr : dp_addr_r;
   assign rd_word = rsa_read(rd_addr, acc_nxt, mem_nxt, imm_nxt,
                             {ovf_nxt, z_nxt, aux_nxt, c_nxt},
                             {memwr_last_nxt, skip_last_nxt, state_nxt != ST_IDLE},
                             start ? hwdata[`RSA_CTRL_OP_MSB:`RSA_CTRL_OP_LSB] : op_r,
                             start ? hwdata[`RSA_CTRL_BIT_MSB:`RSA_CTRL_BIT_LSB] : bit_r);

   // all state flops; hreadyout stalls any data phase while executing
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_r <= `RSA_RST_BYTE;
         mem_r <= `RSA_RST_BYTE;
         imm_r <= `RSA_RST_BYTE;
         c_r <= 1'b0;
         aux_r <= 1'b0;
         z_r <= 1'b0;
         ovf_r <= 1'b0;
         op_r <= `RSA_RST_OP;
         bit_r <= 3'h0;
         skip_last_r <= 1'b0;
         memwr_last_r <= 1'b0;
         state_r <= ST_IDLE;
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         skip_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         mem_r <= mem_nxt;
         imm_r <= imm_nxt;
         c_r <= c_nxt;
         aux_r <= aux_nxt;
         z_r <= z_nxt;
         ovf_r <= ovf_nxt;
         skip_last_r <= skip_last_nxt;
         memwr_last_r <= memwr_last_nxt;
         state_r <= state_nxt;
         if (start) begin
            op_r <= hwdata[`RSA_CTRL_OP_MSB:`RSA_CTRL_OP_LSB];
            bit_r <= hwdata[`RSA_CTRL_BIT_MSB:`RSA_CTRL_BIT_LSB];
         end
         // address phase capture; a completed phase frees the slot
         if (accept) begin
            dp_valid_r <= 1'b1;
            dp_write_r <= hwrite;
            dp_addr_r <= {haddr[7:2], 2'b00};
         end else if (hreadyout) begin
            dp_valid_r <= 1'b0;
         end
         hrdata <= rd_word;
         hreadyout <= (state_nxt == ST_IDLE);
         hresp <= 1'b0;
         // fetch stage discards its prefetched word during the dummy cycle
         skip_o <= (state_nxt == ST_DUMMY); // RL14
         done_o <= (state_r == ST_EXEC && !skip) || (state_r == ST_DUMMY);
      end
   end

endmodule // rsa_alu
`default_nettype wire

//--- rsa_alu_chk.sv
/*
 port checker for the rotate / subtract / skip execution block.
 assumes a non-pipelined single bus master and hready tied to hreadyout.
*/
`timescale 1ns/100ps
`default_nettype none
module rsa_alu_chk (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus side
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // fetch side
   input wire logic skip_o,
   input wire logic done_o
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // a control write taken on the bus launches one operation
   wire logic go = hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h00;

   property p_launch; go |=> hreadyout ##1 !hreadyout; endproperty
   a_launch: assert property (p_launch) else $error("no execute stall");
   property p_exec_end; $fell(hreadyout) |=> hreadyout != skip_o; endproperty
   a_exec_end: assert property (p_exec_end) else $error("bad end of execute");
   property p_stall_max; $fell(hreadyout) |-> ##[1:2] hreadyout; endproperty
   a_stall_max: assert property (p_stall_max) else $error("stall too long");
   property p_skip_one; skip_o |=> !skip_o; endproperty
   a_skip_one: assert property (p_skip_one) else $error("dummy cycle too long");
   property p_skip_stall; skip_o |-> !hreadyout && !$past(hreadyout); endproperty
   a_skip_stall: assert property (p_skip_stall) else $error("dummy not stalled");
   property p_skip_done; skip_o |=> done_o && hreadyout; endproperty
   a_skip_done: assert property (p_skip_done) else $error("no finish after dummy");
   property p_done_one; done_o |=> !done_o; endproperty
   a_done_one: assert property (p_done_one) else $error("finish pulse too long");
   property p_done_cause; done_o |-> !$past(hreadyout) && hreadyout; endproperty
   a_done_cause: assert property (p_done_cause) else $error("finish without operation");
   property p_okay; !hresp; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
endmodule // rsa_alu_chk

bind rsa_alu rsa_alu_chk u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .skip_o(skip_o), .done_o(done_o)
);
`default_nettype wire

//--- rsa_fetch_model.sv
/*
 fetch stage stand-in: counts fetched words thrown away by skips.
 assumes skip_o marks the single dummy cycle of a skip.
*/
`timescale 1ns/100ps
`default_nettype none
module rsa_fetch_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // from the execution block
   input wire logic skip_o,
   // words discarded so far
   output var int dropped
);
   // one prefetched word dies per dummy cycle; counted, not stored
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dropped <= 0;
      end else if (skip_o) begin
         dropped <= dropped + 1;
      end
   end
endmodule // rsa_fetch_model
`default_nettype wire

//--- rsa_alu_tb.sv
/*
 self-checking bench: reset values, a table of operations, then status, unmapped, back-to-back
 and mid-operation reset cases. assumes rsa_alu_map.vh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rsa_alu_map.vh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; $display("Error %s expected %h seen %h", nm, e, s); end end
module rsa_alu_tb;
   // bus, fetch side and bench state
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, skip_o, done_o;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rdat, nwait;
   logic [63:0] r;
   wire logic hready = hreadyout;
   int num_errors, checks_done, cyc, drp, d0, ndone, n0;
   // op bit acc mem imm flg | acc mem flg skip (flags: ovf z aux c)
   logic [63:0] rows [24] = '{
      64'h00_0_55_81_00_E_55_02_F_0,
      64'h01_0_00_40_00_F_81_40_E_0,
      64'h02_0_33_01_00_5_33_80_5_0,
      64'h03_0_00_A6_00_A_53_A6_A_0,
      64'h04_0_77_03_00_2_77_01_3_0,
      64'h05_0_00_02_00_D_81_02_C_0,
      64'h06_0_10_01_00_0_0E_01_1_0,
      64'h07_0_80_01_00_1_80_7F_9_0,
      64'h08_0_05_05_00_8_00_05_7_0,
      64'h09_0_01_02_00_F_01_FF_0_0,
      64'h0A_0_7F_33_FF_0_80_33_A_0,
      64'h0B_0_22_01_00_5_22_00_5_1,
      64'h0B_0_22_00_00_0_22_FF_0_0,
      64'h0C_0_44_01_00_A_00_01_A_1,
      64'h0D_0_00_FF_00_3_00_00_3_1,
      64'h0E_0_00_7F_00_C_80_7F_C_0,
      64'h0F_7_11_80_00_6_11_80_6_1,
      64'h0F_0_11_FE_00_6_11_FE_6_0,
      64'h10_0_12_00_00_9_12_FF_9_0,
      64'h11_3_12_00_00_4_12_08_4_0,
      64'h11_7_00_7F_00_0_00_FF_0_0,
      64'h12_0_9A_3C_00_1_9A_C3_1_0,
      64'h13_0_00_5A_00_2_A5_5A_2_0,
      64'h14_0_12_34_00_F_12_34_F_0};

   rsa_alu u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .skip_o(skip_o), .done_o(done_o)
   );
   rsa_fetch_model u_fetch (.hclk(hclk), .hresetn(hresetn), .skip_o(skip_o), .dropped(drp));

   // one single word transfer; address-phase wait cycles land in nwait
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      begin
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= a;
         hwrite <= w;
         nwait = 32'h0;
         @(posedge hclk);
         while (hreadyout !== 1'b1) begin
            nwait++;
            @(posedge hclk);
         end
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= wd;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         rdat = hrdata;
      end
   endtask

   task do_reset;
      begin
         hresetn <= 1'b0;
         repeat (12) @(posedge hclk);
         hresetn <= 1'b1;
         @(posedge hclk);
      end
   endtask

   // every word below 0x20, unmapped ones too, reads zero after reset
   task zeros;
      begin
         `CHK("ready", 1'b1, hreadyout)
         for (int a = 0; a < 32; a += 4) begin
            xfer(1'b0, 8'(a), 32'h0);
            `CHK("reset value", 32'h0, rdat)
         end
      end
   endtask

   task close_out;
      begin
         $display("checks %0d errors %0d", checks_done, num_errors);
         if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cyc++;
      // finish pulses stand one cycle, so each is counted once
      if (done_o === 1'b1) ndone++;
      if (cyc == 3000) begin
         num_errors++;
         close_out;
      end
   end

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, haddr, htrans, hwdata} = '0;
      hsize = 3'h2;
      do_reset;
      zeros;
      for (int i = 0; i < 24; i++) begin
         r = rows[i];
         xfer(1'b1, `RSA_OFS_ACC, {24'h0, r[51:44]});
         xfer(1'b1, `RSA_OFS_MEM, {24'h0, r[43:36]});
         xfer(1'b1, `RSA_OFS_IMM, {24'h0, r[35:28]});
         xfer(1'b1, `RSA_OFS_FLAGS, {28'h0, r[27:24]});
         d0 = drp;
         n0 = ndone;
         xfer(1'b1, `RSA_OFS_CTRL, {21'h0, r[54:52], 3'h0, r[60:56]});
         xfer(1'b0, `RSA_OFS_ACC, 32'h0);
         `CHK("stall", 32'h1 + r[3:0], nwait)
         `CHK("acc", {24'h0, r[23:16]}, rdat)
         xfer(1'b0, `RSA_OFS_MEM, 32'h0);
         `CHK("mem", {24'h0, r[15:8]}, rdat)
         xfer(1'b0, `RSA_OFS_FLAGS, 32'h0);
         `CHK("flags", {28'h0, r[7:4]}, rdat)
         xfer(1'b0, `RSA_OFS_STATUS, 32'h0);
         `CHK("skipped", r[0], rdat[1])
         `CHK("dropped", int'(r[3:0]), drp - d0)
         `CHK("done", 1, ndone - n0)
      end
      // status is read only, unmapped writes vanish, only the low byte is kept
      xfer(1'b1, `RSA_OFS_STATUS, 32'h00000007);
      xfer(1'b0, `RSA_OFS_STATUS, 32'h0);
      `CHK("status", 2'b00, rdat[1:0])
      xfer(1'b1, 8'h18, 32'h000000A5);
      xfer(1'b0, 8'h18, 32'h0);
      `CHK("unmapped", 32'h0, rdat)
      xfer(1'b1, `RSA_OFS_IMM, 32'hFFFFFF12);
      xfer(1'b0, `RSA_OFS_IMM, 32'h0);
      `CHK("imm", 32'h00000012, rdat)
      // two launches back to back: the second waits out the first
      xfer(1'b1, `RSA_OFS_MEM, 32'h00000002);
      d0 = drp;
      n0 = ndone;
      xfer(1'b1, `RSA_OFS_CTRL, {27'h0, `RSA_OP_DECREMENT_SKIP_ZERO});
      xfer(1'b1, `RSA_OFS_CTRL, {27'h0, `RSA_OP_DECREMENT_SKIP_ZERO});
      `CHK("wait1", 32'h1, nwait)
      xfer(1'b0, `RSA_OFS_MEM, 32'h0);
      `CHK("wait2", 32'h2, nwait)
      `CHK("mem2", 32'h0, rdat)
      `CHK("drop2", 1, drp - d0)
      `CHK("done2", 2, ndone - n0)
      // reset lands in the execute cycle of a set-byte
      xfer(1'b1, `RSA_OFS_ACC, 32'h000000FF);
      xfer(1'b1, `RSA_OFS_CTRL, {27'h0, `RSA_OP_SET_BYTE});
      do_reset;
      zeros;
      `CHK("drop0", 0, drp)
      close_out;
   end
endmodule // rsa_alu_tb
`default_nettype wire
